// >>> rtl/bpd_top.sv
// Full-bridge direction reversal, pair polarity, start-up flag and auto-shutdown.
// Assumes the period timer, its tick and the raw duty-compare PWM come from
// same-clock logic; comparator and interrupt pins are asynchronous.
//
// What this block does
// - Direction change applies from next PWM cycle
// - Four counts early: B/D off, A/C swap
// - Modulation resumes at following period start
// - Full-bridge inserts no dead-band delay
// - Direction write accepted anytime, deferred
// - Two-bit field sets pair polarities independently
// - Period flag set at second period
// - Three-bit select chooses shutdown trigger sources
// - Firmware writing one forces shutdown event
// - Status bit sticks until cleared
// - Shutdown forces outputs asynchronously
// - A/C field: low, high or tri-state
// - B/D field: low, high or tri-state
// - Shutdown holds while trigger level persists
// - Status writes ignored while condition present
// - Restart only at next period start
// - Auto restart clears status when condition ends
// - Comparator sync delays by auxiliary timer
// - Status bit 7, source bits 6-4
// - Forward: A on, D mod; reverse: C on, B mod
// - Auto restart enable at bit 7
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module bpd_top #(
  parameter int TMR_W = 8
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic TMR_TICK_I,
  input wire logic [TMR_W-1:0] TMR_COUNT_I,
  input wire logic [TMR_W-1:0] TMR_PERIOD_I,
  input wire logic PWM_RAW_I,
  input wire logic AUX_SYNC_TICK_I,
  input wire logic CMP1_I,
  input wire logic CMP2_I,
  input wire logic INT_PIN_I,
  output logic BRIDGE_OUT_A_O,
  output logic BRIDGE_OUT_B_O,
  output logic BRIDGE_OUT_C_O,
  output logic BRIDGE_OUT_D_O,
  output logic BRIDGE_OE_N_A_O,
  output logic BRIDGE_OE_N_B_O,
  output logic BRIDGE_OE_N_C_O,
  output logic BRIDGE_OE_N_D_O,
  output logic SHUTDOWN_O
);

  localparam logic [TMR_W-1:0] LEAD_CNT = TMR_W'(bpd_pkg::SWITCH_LEAD_CNT);

  logic [7:0] ctrl_q;
  logic [7:0] dly_q;
  logic [6:0] asd_q;
  logic [7:0] drv_q;
  logic ase_q;
  logic ase_d;
  logic tpf_q;
  logic [7:0] rdata_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [1:0] cmp_aux_q;
  logic seen_first_q;
  logic run_q;
  bpd_pkg::bpd_dir_state_t state_q;
  logic target_q;
  logic applied_q;
  logic [3:0] norm_q;
  logic [3:0] act_d;
  logic [3:0] out_w;
  logic [3:0] oe_n_w;

  logic wr_ctrl;
  logic wr_dly;
  logic wr_asd;
  logic wr_stat;
  logic wr_drv;
  logic pwm_en;
  logic full_mode;
  logic half_mode;
  logic dir_sel;
  logic sync_en;
  logic [2:0] src_sel;
  logic [1:0] cmp_sync_val;
  logic [1:0] cmp_async_val;
  logic cond_sync;
  logic cond_async;
  logic sd_now;
  logic period_start;
  logic lead_pt;
  logic dir_now;
  logic mod_ok;

  assign wr_ctrl = CE_I & WR_I & (ADDR_I == bpd_pkg::ADDR_CTRL);
  assign wr_dly = CE_I & WR_I & (ADDR_I == bpd_pkg::ADDR_DELAY);
  assign wr_asd = CE_I & WR_I & (ADDR_I == bpd_pkg::ADDR_ASD);
  assign wr_stat = CE_I & WR_I & (ADDR_I == bpd_pkg::ADDR_STAT);
  assign wr_drv = CE_I & WR_I & (ADDR_I == bpd_pkg::ADDR_DRV);

  assign pwm_en = ctrl_q[bpd_pkg::CTRL_EN_BIT];
  assign full_mode = ctrl_q[bpd_pkg::CTRL_FULL_BIT];
  assign half_mode = ~full_mode & ctrl_q[bpd_pkg::CTRL_HALF_BIT];
  assign dir_sel = ctrl_q[bpd_pkg::CTRL_DIR_BIT];
  assign sync_en = drv_q[bpd_pkg::DRV_SYNC_BIT];
  assign src_sel = asd_q[bpd_pkg::ASD_SRC_LSB +: 3];

  // Period boundary: the tick that takes the timer from PERIOD back to zero
  assign period_start = CE_I & TMR_TICK_I & (TMR_COUNT_I == TMR_PERIOD_I);
  // A period shorter than the lead count wraps this compare; keep PERIOD at four or more
  // Tick into count PERIOD-3, leaving four counts to the period end
  assign lead_pt = CE_I & TMR_TICK_I & (TMR_COUNT_I == TMR_PERIOD_I - LEAD_CNT);

  // Pin synchronisers, read by nothing but the next stage
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
    end else if (CE_I) begin
      pin_s1_q <= {INT_PIN_I, CMP2_I, CMP1_I};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Comparator levels sampled only on the auxiliary timer tick
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cmp_aux_q <= 2'h3;
    end else if (CE_I && AUX_SYNC_TICK_I) begin
      cmp_aux_q <= pin_s2_q[1:0];
    end
  end

  assign cmp_sync_val = sync_en ? cmp_aux_q : pin_s2_q[1:0];
  // With comparator sync off the fast path uses the raw pins so that shutdown needs no clock edge
  assign cmp_async_val = sync_en ? cmp_aux_q : {CMP2_I, CMP1_I};

  // Raw pins bypass the synchronisers by intent; the status bit uses the synced copy
  // Each source bit adds a low-level trigger; 000 disables all
  assign cond_sync = (src_sel[bpd_pkg::SRC_CMP1_BIT] & ~cmp_sync_val[0])
                   | (src_sel[bpd_pkg::SRC_CMP2_BIT] & ~cmp_sync_val[1])
                   | (src_sel[bpd_pkg::SRC_PIN_BIT] & ~pin_s2_q[2]);
  assign cond_async = (src_sel[bpd_pkg::SRC_CMP1_BIT] & ~cmp_async_val[0])
                    | (src_sel[bpd_pkg::SRC_CMP2_BIT] & ~cmp_async_val[1])
                    | (src_sel[bpd_pkg::SRC_PIN_BIT] & ~INT_PIN_I);

  // Level sensitive: outputs stay forced while the trigger level lasts
  assign sd_now = ase_q | cond_async;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ctrl_q <= bpd_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= WDATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      dly_q <= bpd_pkg::DELAY_RST;
    end else if (wr_dly) begin
      dly_q <= WDATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      asd_q <= bpd_pkg::ASD_RST[6:0];
    end else if (wr_asd) begin
      asd_q <= WDATA_I[6:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      drv_q <= bpd_pkg::DRV_RST;
    end else if (wr_drv) begin
      drv_q <= WDATA_I;
    end
  end

  // Event status: any set beats any clear in the same cycle
  // A write of zero is refused while the synced condition stands
  always_comb begin
    ase_d = ase_q;
    if (cond_sync || (wr_asd && WDATA_I[bpd_pkg::ASD_STAT_BIT])) begin
      ase_d = 1'b1;
    end else if (wr_asd && !cond_sync) begin
      ase_d = 1'b0;
    end else if (dly_q[bpd_pkg::DLY_RESTART_BIT] && !cond_sync) begin
      ase_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ase_q <= bpd_pkg::ASD_RST[bpd_pkg::ASD_STAT_BIT];
    end else if (CE_I) begin
      ase_q <= ase_d;
    end
  end

  // First period start after enabling opens the output, the second sets the flag
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      seen_first_q <= 1'b0;
    end else if (CE_I) begin
      if (!pwm_en) begin
        seen_first_q <= 1'b0;
      end else if (period_start) begin
        seen_first_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      tpf_q <= 1'b0;
    end else if (CE_I) begin
      if (period_start && pwm_en && seen_first_q) begin
        tpf_q <= 1'b1;
      end else if (wr_stat && WDATA_I[bpd_pkg::STAT_TPF_BIT]) begin
        tpf_q <= 1'b0;
      end
    end
  end

  // Waveforms only ever start on a period boundary, so no runt pulse appears
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      run_q <= 1'b0;
    end else if (CE_I) begin
      if (!pwm_en || ase_q || cond_sync) begin
        run_q <= 1'b0;
      end else if (period_start) begin
        run_q <= 1'b1;
      end
    end
  end

  // Direction sequencer
  // A direction written after the lead point waits for the next period's lead point
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_q <= bpd_pkg::BPD_DIR_STEADY;
      target_q <= 1'b0;
      applied_q <= 1'b0;
    end else if (CE_I) begin
      case (state_q)
        bpd_pkg::BPD_DIR_STEADY: begin
          if (!full_mode) begin
            applied_q <= dir_sel;
          end else if (lead_pt && (dir_sel != applied_q)) begin
            state_q <= bpd_pkg::BPD_DIR_SWAP;
            target_q <= dir_sel;
          end
        end
        bpd_pkg::BPD_DIR_SWAP: begin
          if (period_start || !full_mode) begin
            state_q <= bpd_pkg::BPD_DIR_STEADY;
            applied_q <= target_q;
          end
        end
        default: begin
          state_q <= bpd_pkg::BPD_DIR_STEADY;
        end
      endcase
    end
  end

  assign dir_now = (state_q == bpd_pkg::BPD_DIR_SWAP) ? target_q : applied_q;
  assign mod_ok = run_q & (state_q == bpd_pkg::BPD_DIR_STEADY);

  // Active levels before polarity; full bridge has no dead-band stage
  always_comb begin
    act_d = 4'h0;
    if (full_mode) begin
      act_d[0] = run_q & ~dir_now;
      act_d[2] = run_q & dir_now;
      act_d[3] = mod_ok & ~dir_now & PWM_RAW_I;
      act_d[1] = mod_ok & dir_now & PWM_RAW_I;
    end else if (half_mode) begin
      act_d[0] = run_q & PWM_RAW_I;
      act_d[1] = run_q & ~PWM_RAW_I;
    end else begin
      act_d[0] = run_q & PWM_RAW_I;
    end
  end

  // Per pin: polarity, then the asynchronous shutdown override
  for (genvar i = 0; i < 4; i++) begin : g_pin
    localparam int SS_LSB = (i % 2 == 0) ? bpd_pkg::ASD_AC_LSB : bpd_pkg::ASD_BD_LSB;
    localparam int POL_BIT = (i % 2 == 0) ? bpd_pkg::CTRL_POL_AC_BIT
                                          : bpd_pkg::CTRL_POL_BD_BIT;
    logic [1:0] ss;
    logic drv_on;
    assign ss = asd_q[SS_LSB +: 2];
    assign drv_on = drv_q[i];

    // Registered so the pins cannot glitch; normal outputs trail the timer by one cycle
    always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
        norm_q[i] <= 1'b0;
      end else if (CE_I) begin
        norm_q[i] <= act_d[i] ^ ctrl_q[POL_BIT];
      end
    end

    // Combinational on purpose: shutdown must not wait for a clock edge
    always_comb begin
      out_w[i] = norm_q[i];
      oe_n_w[i] = ~drv_on;
      if (sd_now && drv_on) begin
        if (ss[bpd_pkg::SS_TRI_BIT]) begin
          out_w[i] = 1'b0;
          oe_n_w[i] = 1'b1;
        end else begin
          out_w[i] = (ss == bpd_pkg::SS_DRIVE_HIGH);
          oe_n_w[i] = 1'b0;
        end
      end
    end
  end

  assign BRIDGE_OUT_A_O = out_w[0];
  assign BRIDGE_OUT_B_O = out_w[1];
  assign BRIDGE_OUT_C_O = out_w[2];
  assign BRIDGE_OUT_D_O = out_w[3];
  assign BRIDGE_OE_N_A_O = oe_n_w[0];
  assign BRIDGE_OE_N_B_O = oe_n_w[1];
  assign BRIDGE_OE_N_C_O = oe_n_w[2];
  assign BRIDGE_OE_N_D_O = oe_n_w[3];
  assign SHUTDOWN_O = sd_now;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rdata_q <= 8'h00;
    end else if (CE_I) begin
      rdata_q <= 8'h00;
      if (RD_I) begin
        case (ADDR_I)
          bpd_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
          bpd_pkg::ADDR_DELAY: rdata_q <= dly_q;
          bpd_pkg::ADDR_ASD: rdata_q <= {ase_q, asd_q};
          bpd_pkg::ADDR_STAT: begin
            rdata_q[bpd_pkg::STAT_TPF_BIT] <= tpf_q;
            rdata_q[bpd_pkg::STAT_DIR_BIT] <= applied_q;
            rdata_q[bpd_pkg::STAT_COND_BIT] <= cond_sync;
          end
          bpd_pkg::ADDR_DRV: rdata_q <= {3'h0, drv_q[4:0]};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign RDATA_O = rdata_q;

endmodule // bpd_top

`default_nettype wire

// >>> rtl/bpd_pkg.sv
// Package for the full-bridge direction, polarity and auto-shutdown block.
// Assumes an 8-bit register port and a period timer that runs in the same clock domain.
package bpd_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_DELAY = 3'h1;
  localparam logic [2:0] ADDR_ASD = 3'h2;
  localparam logic [2:0] ADDR_STAT = 3'h3;
  localparam logic [2:0] ADDR_DRV = 3'h4;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam logic [7:0] ASD_RST = 8'h00;
  localparam logic [7:0] DRV_RST = 8'h00;

  // capture_pwm_control_reg fields
  localparam int CTRL_DIR_BIT = 7;
  localparam int CTRL_FULL_BIT = 6;
  localparam int CTRL_HALF_BIT = 5;
  localparam int CTRL_EN_BIT = 2;
  localparam int CTRL_POL_AC_BIT = 1;
  localparam int CTRL_POL_BD_BIT = 0;

  // pwm_delay_control_reg fields
  localparam int DLY_RESTART_BIT = 7;

  // auto_shutdown_control fields
  localparam int ASD_STAT_BIT = 7;
  localparam int ASD_SRC_LSB = 4;
  localparam int ASD_AC_LSB = 2;
  localparam int ASD_BD_LSB = 0;

  // Source select bits: each set bit adds one trigger
  localparam int SRC_CMP1_BIT = 0;
  localparam int SRC_CMP2_BIT = 1;
  localparam int SRC_PIN_BIT = 2;

  // Shutdown state codes per pin pair
  localparam logic [1:0] SS_DRIVE_LOW = 2'b00;
  localparam logic [1:0] SS_DRIVE_HIGH = 2'b01;
  localparam int SS_TRI_BIT = 1;

  // Status and driver register fields
  localparam int STAT_TPF_BIT = 0;
  localparam int STAT_DIR_BIT = 1;
  localparam int STAT_COND_BIT = 2;
  localparam int DRV_SYNC_BIT = 4;

  // Timer counts before period end at which a direction swap begins
  localparam int SWITCH_LEAD_CNT = 4;

  typedef enum logic [0:0] {
    BPD_DIR_STEADY = 1'b0,
    BPD_DIR_SWAP = 1'b1
  } bpd_dir_state_t;

endpackage : bpd_pkg

// >>> dv/bpd_monitor.sv
// Concurrent checks on the ports of the bridge direction and shutdown block.
// Assumes it is bound to bpd_top; it shadows register writes itself.
`timescale 1ns/1ns
`default_nettype none
module bpd_chk (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic CMP1_I,
  input wire logic INT_PIN_I,
  input wire logic BRIDGE_OUT_A_O,
  input wire logic BRIDGE_OUT_B_O,
  input wire logic BRIDGE_OUT_D_O,
  input wire logic BRIDGE_OE_N_A_O,
  input wire logic BRIDGE_OE_N_B_O,
  input wire logic BRIDGE_OE_N_C_O,
  input wire logic BRIDGE_OE_N_D_O,
  input wire logic SHUTDOWN_O
);
  logic [7:0] asd_q, drv_q, ctl_q, dly_q;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      asd_q <= 8'h00;
      drv_q <= 8'h00;
      ctl_q <= 8'h00;
      dly_q <= 8'h00;
    end else if (WR_I && CE_I) begin
      case (ADDR_I)
        bpd_pkg::ADDR_ASD: asd_q <= WDATA_I;
        bpd_pkg::ADDR_DRV: drv_q <= WDATA_I;
        bpd_pkg::ADDR_CTRL: ctl_q <= WDATA_I;
        bpd_pkg::ADDR_DELAY: dly_q <= WDATA_I;
        default: ;
      endcase
    end
  end
  a_rd_idle_zero: assert property (
    !$past(RD_I && CE_I) |-> RDATA_O == 8'h00) else $error("read data not idle");
  a_rd_asd_cfg: assert property (
    RD_I && CE_I && ADDR_I == bpd_pkg::ADDR_ASD |=> RDATA_O[6:0] == $past(asd_q[6:0]))
    else $error("shutdown config readback wrong");
  a_cmp1_trip: assert property (
    asd_q[4] && !drv_q[4] && !CMP1_I |-> SHUTDOWN_O) else $error("cmp1 trip missed");
  a_pin_trip: assert property (
    asd_q[6] && !INT_PIN_I |-> SHUTDOWN_O) else $error("pin trip missed");
  a_ac_drive: assert property (
    SHUTDOWN_O && drv_q[0] && !asd_q[3] |-> BRIDGE_OUT_A_O == asd_q[2] && !BRIDGE_OE_N_A_O)
    else $error("pair ac safe level wrong");
  a_ac_tri: assert property (
    SHUTDOWN_O && asd_q[3] |-> BRIDGE_OE_N_C_O) else $error("pair ac not released");
  a_bd_drive: assert property (
    SHUTDOWN_O && drv_q[3] && !asd_q[1] |-> BRIDGE_OUT_D_O == asd_q[0] && !BRIDGE_OE_N_D_O)
    else $error("pair bd safe level wrong");
  a_oe_normal: assert property (
    !SHUTDOWN_O |-> BRIDGE_OE_N_B_O == !drv_q[1]) else $error("driver enable wrong");
  a_fw_event: assert property (
    WR_I && CE_I && ADDR_I == bpd_pkg::ADDR_ASD && WDATA_I[7] |=> SHUTDOWN_O)
    else $error("firmware event ignored");
  a_sd_sticky: assert property (
    $fell(SHUTDOWN_O) && !dly_q[7] |-> $past(WR_I && ADDR_I == bpd_pkg::ADDR_ASD && !WDATA_I[7]))
    else $error("status left without clear");
  a_bd_one_mod: assert property (
    ctl_q[6] && !ctl_q[0] && !SHUTDOWN_O |-> !(BRIDGE_OUT_B_O && BRIDGE_OUT_D_O))
    else $error("both b and d active");
endmodule // bpd_chk
bind bpd_top bpd_chk u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CMP1_I(CMP1_I),
  .INT_PIN_I(INT_PIN_I), .BRIDGE_OUT_A_O(BRIDGE_OUT_A_O), .BRIDGE_OUT_B_O(BRIDGE_OUT_B_O),
  .BRIDGE_OUT_D_O(BRIDGE_OUT_D_O), .BRIDGE_OE_N_A_O(BRIDGE_OE_N_A_O),
  .BRIDGE_OE_N_B_O(BRIDGE_OE_N_B_O), .BRIDGE_OE_N_C_O(BRIDGE_OE_N_C_O),
  .BRIDGE_OE_N_D_O(BRIDGE_OE_N_D_O), .SHUTDOWN_O(SHUTDOWN_O));
`default_nettype wire

// >>> dv/bpd_plant.sv
// Period timer, duty compare and sync timer feeding the block.
// Assumes one clock; the timer ticks every cycle to keep periods short.
`timescale 1ns/1ns
`default_nettype none
module bpd_plant #(
  parameter int PER = 9,
  parameter int DUTY = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic tick_o,
  output logic [7:0] count_o,
  output logic [7:0] period_o,
  output logic pwm_o,
  output logic aux_o
);
  logic [7:0] cnt_q;
  logic [2:0] aux_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
      aux_q <= 3'h0;
    end else begin
      cnt_q <= (cnt_q == 8'(PER)) ? 8'h00 : cnt_q + 8'h01;
      aux_q <= aux_q + 3'h1;
    end
  end
  assign tick_o = rst_n_i;
  assign count_o = cnt_q;
  assign period_o = 8'(PER);
  assign pwm_o = cnt_q < 8'(DUTY);
  assign aux_o = aux_q == 3'h0;
endmodule // bpd_plant
`default_nettype wire

// >>> dv/tb.sv
// Register-driven bench for direction change, polarity and shutdown.
// Assumes bpd_plant as timer source and the checker bound to the design.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pr = 1'b0, ce = 1'b1;
  logic [2:0] addr = 3'h0, pins = 3'h7, sv;
  logic [7:0] wdata = 8'h00, rdata, d, cfg, cnt, per;
  logic [1:0] ac, bd;
  logic [3:0] oe_n, tm;
  logic tick, pwm, aux, a, b, c, dd, sd;
  int error_cnt = 0, total_checks = 0, s, i;
  always #10 clk = ~clk;
  always @(posedge clk) pr <= pwm;
  bpd_plant #(.PER(9), .DUTY(8)) u_plant (.clk_i(clk), .rst_n_i(rst_n), .tick_o(tick),
    .count_o(cnt), .period_o(per), .pwm_o(pwm), .aux_o(aux));
  bpd_top DUT (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TMR_TICK_I(tick), .TMR_COUNT_I(cnt),
    .TMR_PERIOD_I(per), .PWM_RAW_I(pwm), .AUX_SYNC_TICK_I(aux), .CMP1_I(pins[0]),
    .CMP2_I(pins[1]), .INT_PIN_I(pins[2]), .BRIDGE_OUT_A_O(a), .BRIDGE_OUT_B_O(b),
    .BRIDGE_OUT_C_O(c), .BRIDGE_OUT_D_O(dd), .BRIDGE_OE_N_A_O(oe_n[3]),
    .BRIDGE_OE_N_B_O(oe_n[2]), .BRIDGE_OE_N_C_O(oe_n[1]), .BRIDGE_OE_N_D_O(oe_n[0]),
    .SHUTDOWN_O(sd));
  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [2:0] ad, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdt(input logic [2:0] ad, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic waitc(input logic [7:0] v);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cnt !== v && n < 64);
    if (cnt !== v) begin
      error_cnt++;
      summarize();
    end
  endtask
  // Outputs as {A,B,C,D}: fixed levels v, mask m follows last sampled duty
  task automatic watch(input int n, input logic [3:0] m, input logic [3:0] v);
    repeat (n) begin
      @(negedge clk);
      chk({4'h0, a, b, c, dd}, {4'h0, v | (pr ? m : 4'h0)});
    end
  endtask
  task automatic trip(input int p, input logic v);
    @(posedge clk);
    pins[p] <= v;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (s = 0; s < 6; s++) begin
      rdt(3'(s), d);
      chk(d, 8'h00);
    end
    wrt(3'h5, 8'hff);
    rdt(3'h5, d);
    chk(d, 8'h00);
    wrt(bpd_pkg::ADDR_ASD, 8'h15);
    rdt(bpd_pkg::ADDR_ASD, d);
    chk(d, 8'h15);
    // A write while the clock enable is low must leave the register alone
    @(posedge clk);
    ce <= 1'b0;
    wrt(bpd_pkg::ADDR_CTRL, 8'h44);
    @(posedge clk);
    ce <= 1'b1;
    rdt(bpd_pkg::ADDR_CTRL, d);
    chk(d, 8'h00);
    $display("test done: registers");
    wrt(bpd_pkg::ADDR_CTRL, 8'h44);
    i = 0;
    do begin
      rdt(bpd_pkg::ADDR_STAT, d);
      i++;
    end while (d[0] !== 1'b1 && i < 20);
    chk(d & 8'h01, 8'h01);
    wrt(bpd_pkg::ADDR_DRV, 8'h0f);
    waitc(8'h01);
    watch(12, 4'b0001, 4'b1000);
    waitc(8'h01);
    wrt(bpd_pkg::ADDR_CTRL, 8'hc4);
    // Pins trail the timer by one cycle, so the swap shows from count 7 through count 0
    watch(4, 4'b0001, 4'b1000);
    watch(4, 4'b0000, 4'b0010);
    watch(10, 4'b0100, 4'b0010);
    rdt(bpd_pkg::ADDR_STAT, d);
    chk(d & 8'h02, 8'h02);
    waitc(8'h01);
    wrt(bpd_pkg::ADDR_CTRL, 8'hc4);
    watch(10, 4'b0100, 4'b0010);
    $display("test done: direction");
    wrt(bpd_pkg::ADDR_DRV, 8'h00);
    @(negedge clk);
    chk({4'h0, oe_n}, 8'h0f);
    wrt(bpd_pkg::ADDR_CTRL, 8'hc6);
    wrt(bpd_pkg::ADDR_DRV, 8'h0f);
    watch(10, 4'b0100, 4'b1000);
    wrt(bpd_pkg::ADDR_DRV, 8'h00);
    wrt(bpd_pkg::ADDR_CTRL, 8'hc4);
    wrt(bpd_pkg::ADDR_DRV, 8'h0f);
    $display("test done: polarity");
    for (s = 1; s < 8; s++) begin
      sv = 3'(s);
      ac = 2'(s % 3);
      bd = 2'((s + 1) % 3);
      cfg = {1'b0, sv, ac, bd};
      tm = {ac[1], bd[1], ac[1], bd[1]};
      wrt(bpd_pkg::ADDR_ASD, cfg);
      if (s != 7) begin
        trip(sv[0] ? (sv[1] ? 2 : 1) : 0, 1'b0);
        repeat (4) @(negedge clk);
        chk({7'h0, sd}, 8'h00);
        trip(sv[0] ? (sv[1] ? 2 : 1) : 0, 1'b1);
      end
      trip(sv[0] ? 0 : (sv[1] ? 1 : 2), 1'b0);
      @(negedge clk);
      chk({7'h0, sd}, 8'h01);
      chk({4'h0, oe_n}, {4'h0, tm});
      chk({4'h0, {a, b, c, dd} & ~tm}, {4'h0, {ac[0], bd[0], ac[0], bd[0]} & ~tm});
      repeat (5) @(posedge clk);
      wrt(bpd_pkg::ADDR_ASD, cfg);
      rdt(bpd_pkg::ADDR_ASD, d);
      chk(d, cfg | 8'h80);
      trip(sv[0] ? 0 : (sv[1] ? 1 : 2), 1'b1);
      repeat (5) @(posedge clk);
      rdt(bpd_pkg::ADDR_ASD, d);
      chk(d, cfg | 8'h80);
      waitc(8'h02);
      wrt(bpd_pkg::ADDR_ASD, cfg);
      @(negedge clk);
      chk({7'h0, c}, 8'h00);
      waitc(8'h00);
      watch(3, 4'b0100, 4'b0010);
    end
    $display("test done: shutdown");
    wrt(bpd_pkg::ADDR_DELAY, 8'h80);
    wrt(bpd_pkg::ADDR_ASD, 8'h80);
    @(negedge clk);
    chk({7'h0, sd}, 8'h01);
    rdt(bpd_pkg::ADDR_ASD, d);
    chk(d, 8'h00);
    wrt(bpd_pkg::ADDR_ASD, 8'h10);
    trip(0, 1'b0);
    repeat (5) @(posedge clk);
    rdt(bpd_pkg::ADDR_ASD, d);
    chk(d, 8'h90);
    trip(0, 1'b1);
    repeat (5) @(posedge clk);
    rdt(bpd_pkg::ADDR_ASD, d);
    chk(d, 8'h10);
    $display("test done: restart");
    wrt(bpd_pkg::ADDR_DRV, 8'h1f);
    trip(0, 1'b0);
    @(negedge clk);
    chk({7'h0, sd}, 8'h00);
    i = 0;
    while (sd !== 1'b1 && i < 24) begin
      @(negedge clk);
      i++;
    end
    chk({7'h0, sd}, 8'h01);
    trip(0, 1'b1);
    repeat (24) @(posedge clk);
    rdt(bpd_pkg::ADDR_ASD, d);
    chk(d, 8'h10);
    $display("test done: sync");
    summarize();
  end
endmodule // tb
`default_nettype wire
